//--- core/ude_core.sv
// USB device enable, flag clearing and status phase sequencing
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "ude_cfg.svh"
module ude_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Bus events from the link
  input wire logic busResetPin,
  input wire logic setupRxPin,
  input wire logic dataDonePin,
  input wire logic errPin,
  input wire logic vbusPin,
  // Link control
  output logic statusAck,
  output logic dplusPullup,
  output logic pingpongPtrClr,
  // Interrupt
  output logic irq
);
  logic [7:0] usbControlReg;
  logic [7:0] otgControlReg;
  logic [7:0] usbPowerControlReg;
  logic [7:0] endpoint0ControlReg;
  logic [7:0] usbIntEnableReg;
  logic [7:0] usbErrorIntEnableReg;
  logic [7:0] usbIntFlagReg;
  logic [7:0] usbErrorFlagReg;
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic [4:0] syncPrev;
  logic [4:0] rise;
  logic [7:0] intSet;
  logic [7:0] errSet;
  logic intPend;
  logic errPend;
  logic active;
  logic [3:0] statusCnt;
  ude_pkg::ude_xfer_t xferState;

  // Pins come from the bus side, two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
      syncPrev <= 5'h00;
    end else begin
      syncA <= {vbusPin, errPin, dataDonePin, setupRxPin, busResetPin};
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  assign rise = syncB & ~syncPrev;
  assign active = usbControlReg[`UDE_CTRL_EN] &
    usbPowerControlReg[`UDE_PWR_ON];

  // Control registers written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usbControlReg <= `UDE_RESET_VAL;
      otgControlReg <= `UDE_RESET_VAL;
      usbPowerControlReg <= `UDE_RESET_VAL;
      endpoint0ControlReg <= `UDE_RESET_VAL;
      usbIntEnableReg <= `UDE_RESET_VAL;
      usbErrorIntEnableReg <= `UDE_RESET_VAL;
    end else if (regWr) begin
      unique case (regAddr)
        `UDE_OFS_CTRL: usbControlReg <= regWdata;
        `UDE_OFS_OTG: otgControlReg <= regWdata;
        `UDE_OFS_PWR: usbPowerControlReg <= regWdata;
        `UDE_OFS_EP0: endpoint0ControlReg <= regWdata;
        `UDE_OFS_IEN: usbIntEnableReg <= regWdata;
        `UDE_OFS_EEN: usbErrorIntEnableReg <= regWdata;
        default: ;
      endcase
    end
  end

  // Pointer reset held while its bit stands
  assign pingpongPtrClr = usbControlReg[`UDE_CTRL_PPRST];
  // Pull-up only with module running and OTG enabled
  assign dplusPullup = otgControlReg[`UDE_OTG_DPPU] & active &
    otgControlReg[`UDE_OTG_EN];

  // Status phase finished without software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xferState <= ude_pkg::UDE_IDLE;
      statusCnt <= 4'h0;
      statusAck <= 1'b0;
    end else begin
      statusAck <= 1'b0;
      unique case (xferState)
        ude_pkg::UDE_IDLE: begin
          if (active && rise[1] &&
              endpoint0ControlReg[`UDE_EP0_RXEN]) begin
            xferState <= ude_pkg::UDE_DATA;
          end
        end
        ude_pkg::UDE_DATA: begin
          if (!active) begin
            xferState <= ude_pkg::UDE_IDLE;
          end else if (rise[2]) begin
            xferState <= ude_pkg::UDE_STATUS;
            statusCnt <= `UDE_STATUS_CYC;
          end
        end
        ude_pkg::UDE_STATUS: begin
          if (statusCnt == 4'h1) begin
            xferState <= ude_pkg::UDE_DONE;
            statusAck <= endpoint0ControlReg[`UDE_EP0_HSHK];
          end
          statusCnt <= statusCnt - 4'h1;
        end
        ude_pkg::UDE_DONE: xferState <= ude_pkg::UDE_IDLE;
      endcase
    end
  end

  // Hardware events only; reset, error and receive-off gated by module activity, token and stall by transfer state
  always_comb begin
    intSet = 8'h00;
    errSet = 8'h00;
    intSet[`UDE_IFLAG_RST] = active & rise[0];
    intSet[`UDE_IFLAG_ERR] = active & rise[3];
    intSet[`UDE_IFLAG_TOK] = xferState == ude_pkg::UDE_DONE;
    intSet[`UDE_IFLAG_STALL] = rise[1] &
      (xferState != ude_pkg::UDE_IDLE);
    errSet[0] = active & rise[3];
    errSet[1] = rise[1] & ~endpoint0ControlReg[`UDE_EP0_RXEN] & active;
  end

  ude_flag_reg intFlags (
    .clk(clk),
    .rst_n(rst_n),
    .setEvt(intSet),
    .clrWr(regWr && regAddr == `UDE_OFS_IFLAG),
    .clrData(regWdata),
    .enable(usbIntEnableReg),
    .flags(usbIntFlagReg),
    .anyPending(intPend)
  );

  ude_flag_reg errFlags (
    .clk(clk),
    .rst_n(rst_n),
    .setEvt(errSet),
    .clrWr(regWr && regAddr == `UDE_OFS_EFLAG),
    .clrData(regWdata),
    .enable(usbErrorIntEnableReg),
    .flags(usbErrorFlagReg),
    .anyPending(errPend)
  );

  assign irq = intPend | errPend;

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `UDE_OFS_CTRL: regRdata <= usbControlReg;
        `UDE_OFS_OTG: regRdata <= otgControlReg;
        `UDE_OFS_PWR: regRdata <= usbPowerControlReg;
        `UDE_OFS_EP0: regRdata <= endpoint0ControlReg;
        `UDE_OFS_IFLAG: regRdata <= usbIntFlagReg;
        `UDE_OFS_IEN: regRdata <= usbIntEnableReg;
        `UDE_OFS_EFLAG: regRdata <= usbErrorFlagReg;
        `UDE_OFS_EEN: regRdata <= usbErrorIntEnableReg;
        // Supply sense for the check before enabling
        `UDE_OFS_STAT: regRdata <= {5'h00, xferState, syncB[4]};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule : ude_core

//--- core/ude_cfg.svh
// Register offsets, field positions and reset values of the USB enable block
// Notes on behaviour
// - Flags are set only by hardware events
// - Writing one clears a flag; zero leaves it
// - Device completes each transfer status phase itself; statusAck only with EP0 bit 3 set
// - OTG bit 7 connects the D+ pull-up, only with OTG bit 2 set and the module enabled and powered
`ifndef UDE_CFG_SVH
`define UDE_CFG_SVH
`define UDE_ADDR_W 4
`define UDE_DATA_W 8
`define UDE_OFS_CTRL 4'h0
`define UDE_OFS_OTG 4'h1
`define UDE_OFS_PWR 4'h2
`define UDE_OFS_EP0 4'h3
`define UDE_OFS_IFLAG 4'h4
`define UDE_OFS_IEN 4'h5
`define UDE_OFS_EFLAG 4'h6
`define UDE_OFS_EEN 4'h7
`define UDE_OFS_STAT 4'h8
`define UDE_CTRL_EN 0
`define UDE_CTRL_PPRST 1
`define UDE_OTG_EN 2
`define UDE_OTG_DPPU 7
`define UDE_PWR_ON 0
`define UDE_EP0_RXEN 0
`define UDE_EP0_HSHK 3
`define UDE_IFLAG_RST 0
`define UDE_IFLAG_ERR 1
`define UDE_IFLAG_TOK 3
`define UDE_IFLAG_STALL 7
`define UDE_RESET_VAL 8'h00
`define UDE_STATUS_CYC 4'h4
`endif

//--- core/ude_pkg.sv
// Types of the USB enable block
package ude_pkg;
  typedef enum logic [1:0] {
    UDE_IDLE = 2'b00,
    UDE_DATA = 2'b01,
    UDE_STATUS = 2'b10,
    UDE_DONE = 2'b11
  } ude_xfer_t;
endpackage : ude_pkg

//--- core/ude_flag_reg.sv
// One write-one-to-clear flag register with enable gating
`timescale 1ns/1ps
`include "ude_cfg.svh"
module ude_flag_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Hardware events
  input wire logic [7:0] setEvt,
  // Software clear
  input wire logic clrWr,
  input wire logic [7:0] clrData,
  // Enables and result
  input wire logic [7:0] enable,
  output logic [7:0] flags,
  output logic anyPending
);
  // Set term last so a same-cycle event survives its clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= `UDE_RESET_VAL;
    end else begin
      flags <= (flags & ~(clrWr ? clrData : 8'h00)) | setEvt;
    end
  end

  assign anyPending = |(flags & enable);
endmodule : ude_flag_reg

//--- sim/ude_core_sva.sv
// Checker of flag, status phase and attach behaviour at the core ports
`timescale 1ns/1ps
module ude_core_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Bus events and link side
  input wire logic busResetPin,
  input wire logic setupRxPin,
  input wire logic dataDonePin,
  input wire logic errPin,
  input wire logic statusAck,
  input wire logic dplusPullup,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Nothing in the event pipeline that could set a flag
  wire quiet = !(busResetPin | setupRxPin | dataDonePin | errPin | statusAck);
  wire flagWr = regWr && (regAddr == 4'h4 || regAddr == 4'h6);
  AST_NO_SW_SET: assert property (quiet[*8] ##0 flagWr && !irq |=> !irq)
    else $error("flag write raised the interrupt");
  AST_W1C: assert property (quiet[*8] ##0 regWr && regAddr == 4'h4
    && regWdata == 8'hff ##1 quiet[*2] ##0 regRd && regAddr == 4'h4
    |=> regRdata == 8'h00) else $error("flags not cleared by ones");
  AST_ACK_PULSE: assert property ($rose(statusAck) |=> !statusAck)
    else $error("status acknowledge longer than one cycle");
  AST_PU_OFF: assert property (regWr && regAddr == 4'h1
    && !regWdata[7] |=> !dplusPullup) else $error("pull-up stayed on");
  AST_PU_ON: assert property ($rose(dplusPullup)
    |-> $past(regWr) && $past(regAddr) <= 4'h2)
    else $error("pull-up rose without a write");
  COV_ACK: cover property ($rose(statusAck));
  COV_ATTACH: cover property ($rose(dplusPullup));
  COV_IRQ: cover property ($rose(irq));
endmodule : ude_core_sva
bind ude_core ude_core_sva chk (.clk, .rst_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .busResetPin, .setupRxPin, .dataDonePin, .errPin,
  .statusAck, .dplusPullup, .irq);

//--- sim/ude_host_model.sv
// Behavioural USB host raising bus event levels
`timescale 1ns/1ps
module ude_host_model (
  // Clock and attach
  input wire logic clk,
  input wire logic dplusPullup,
  // Bus events
  output logic busResetPin,
  output logic setupRxPin,
  output logic dataDonePin,
  output logic errPin,
  output logic vbusPin
);
  logic [3:0] ev = 4'h0;
  assign {errPin, dataDonePin, setupRxPin, busResetPin} = ev;
  // Bus supply off until the bench switches it on
  logic vbusOn = 1'b0;
  assign vbusPin = vbusOn;
  task automatic supply(input logic on);
    @(posedge clk);
    vbusOn <= on;
  endtask : supply
  task automatic evt(input logic [3:0] m);
    // No SETUP before the device has attached
    if (!dplusPullup) m[1] = 1'b0;
    @(posedge clk);
    ev <= m;
    repeat (4) @(posedge clk);
    ev <= 4'h0;
  endtask : evt
endmodule : ude_host_model

//--- sim/tb.sv
// Bench for the USB enable block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic busResetPin, setupRxPin, dataDonePin, errPin, vbusPin;
  logic statusAck, dplusPullup, pingpongPtrClr, irq;
  int fails = 0, checked = 0, cyc = 0;
  always #25 clk = ~clk;
  ude_host_model host (.clk, .dplusPullup, .busResetPin, .setupRxPin,
    .dataDonePin, .errPin, .vbusPin);
  ude_core dut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .busResetPin, .setupRxPin, .dataDonePin, .errPin, .vbusPin,
    .statusAck, .dplusPullup, .pingpongPtrClr, .irq);
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge clk);
    regWr <= 1'b0;
    // Let the write settle before anyone looks at the outputs
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask : rd
  task automatic stop_test;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
    rd(4'hf, 8'h00);
    host.supply(1'b1);
    wr(4'h0, 8'h02);
    chk({7'h0, pingpongPtrClr}, 8'h01);
    wr(4'h0, 8'h00);
    chk({7'h0, pingpongPtrClr}, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h4, 8'hff);
    wr(4'h6, 8'hff);
    rd(4'h8, 8'h01);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h04);
    wr(4'h3, 8'h09);
    wr(4'h2, 8'h01);
    chk({7'h0, dplusPullup}, 8'h00);
    wr(4'h1, 8'h84);
    chk({7'h0, dplusPullup}, 8'h01);
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h00);
    host.evt(4'h1);
    repeat (4) @(posedge clk);
    wr(4'h5, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h01);
    wr(4'h5, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    // Clear lands on the edge that sets the flag
    fork
      host.evt(4'h1);
      begin
        repeat (2) @(posedge clk);
        wr(4'h4, 8'h01);
      end
    join
    rd(4'h4, 8'h01);
    wr(4'h4, 8'h01);
    // Second SETUP while busy raises the stall flag
    host.evt(4'h2);
    host.evt(4'h2);
    host.evt(4'h4);
    for (int n = 0; n < 30 && statusAck !== 1'b1; n++) @(negedge clk);
    chk({7'h0, statusAck}, 8'h01);
    repeat (3) @(posedge clk);
    rd(4'h4, 8'h88);
    host.evt(4'h8);
    repeat (4) @(posedge clk);
    rd(4'h6, 8'h01);
    // SETUP with endpoint 0 receive off is an error
    wr(4'h3, 8'h08);
    host.evt(4'h2);
    repeat (4) @(posedge clk);
    rd(4'h6, 8'h03);
    stop_test;
  end
endmodule : tb
